// [design/serial_irq_pkg.sv]
// Shared constants and types for the serialized interrupt slave agent
package serial_irq_pkg;

    // =======================================================
    // Register map (byte addresses on the Wishbone bus)
    localparam logic [3:0] ADDR_SLOT_OWN = 4'h0;
    localparam logic [3:0] ADDR_SMI_EN2 = 4'h4;
    localparam logic [3:0] ADDR_OSC_CFG = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;

    // =======================================================
    // Field positions and reset values
    localparam int SMI_FRAME_BIT = 6;
    localparam int SMI_PIN_BIT = 7;
    localparam int XTAL_LOAD_BIT = 6;
    localparam logic [15:0] SLOT_OWN_RESET = 16'h0000;
    localparam logic [7:0] SMI_EN2_RESET = 8'h00;
    localparam logic [7:0] OSC_CFG_RESET = 8'h00;

    // =======================================================
    // Link framing figures, in link clocks
    localparam int NUM_LINES = 16;
    localparam int SMI_LINE = 2;
    localparam logic [2:0] STOP_QUIET_WIDTH = 3'd2;
    localparam logic [1:0] START_HOLDOFF = 2'd1;
    localparam logic [1:0] PHASE_TURN = 2'd0;
    localparam logic [1:0] PHASE_SAMPLE = 2'd1;
    localparam logic [1:0] PHASE_RECOVER = 2'd2;
    localparam logic [4:0] FIRST_FRAME = 5'd1;
    localparam logic [4:0] LAST_FRAME = 5'd16;

    // =======================================================
    // Types
    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_DRIVE_START,
        LINK_START,
        LINK_FRAMES,
        LINK_STOP
    } link_state_e;

    typedef struct packed {
        logic [15:0] pending;
        logic [2:0] reserved_hi;
        logic [4:0] frame;
        logic [4:0] reserved_lo;
        logic [2:0] stop_width;
    } status_s;

    typedef struct packed {
        logic oe;
        logic level;
    } pin_drive_s;

endpackage : serial_irq_pkg

// [design/serial_irq_slave_agent.sv]
// Serialized interrupt slave agent with Wishbone register access
//
// Function
// - Quiet idle: any agent starts with one-clock low
// - After start pulse release, never drive high
// - No start while link is active
// - Line change starts frame unless deliverable now
// - Continuous mode: only host starts, slaves passive
// - Mode changes at stop; measure every stop
// - Reset leaves link in continuous mode
// - Count three-clock frames from start rising edge
// - Sample phase: drive low only if line low
// - Recovery: drive high only after own low
// - Turn-around phase: release the wire
// - Report regardless of who started the cycle
// - Frame n samples at clock 3n-1
// - Period three shares management interrupt and line two
// - Period fourteen carries line thirteen
// - Enable bits six and seven route management interrupt
// - Power-good low: ignore bus, disable IR timeout
// - Bit six selects crystal load capacitance
// - Start allowed two clocks after quiet stop
// - Release wire in reset, continuous idle after
// - Drive and sample on link clock rising edge
`timescale 1ns/10ps

module serial_irq_slave_agent #(
    parameter int NUM_LINES = serial_irq_pkg::NUM_LINES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Interrupt sources from the logical devices
    input wire logic [NUM_LINES-1:0] irq_level_i,
    input wire logic smi_active_i,
    output logic system_mgmt_interrupt_n_o,
    // Supply supervision and oscillator
    input wire logic internal_power_good_i,
    output logic ir_timeout_enable_o,
    output logic crystal_load_select_o,
    // Serial interrupt wire and its clock
    input wire logic link_clk_i,
    input wire logic sirq_i,
    output logic sirq_o,
    output logic sirq_oe_o
);

    // =======================================================
    // Synchronisers for pins from outside the clock domain
    logic [1:0] link_clk_sync;
    logic [1:0] sirq_sync;
    logic [1:0] pg_sync;
    logic link_clk_prev;
    logic link_rise;
    logic line_now;
    logic power_good;
    logic sirq_prev;

    // Two stages each; only the second stage feeds logic
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            link_clk_sync <= 2'b00;
            sirq_sync <= 2'b11;
            sirq_prev <= 1'b1;
            pg_sync <= 2'b00;
            link_clk_prev <= 1'b0;
        end
        else
        begin
            link_clk_sync <= {link_clk_sync[0], link_clk_i};
            sirq_sync <= {sirq_sync[0], sirq_i};
            sirq_prev <= sirq_sync[1];
            pg_sync <= {pg_sync[0], internal_power_good_i};
            link_clk_prev <= link_clk_sync[1];
        end
    end

    assign link_rise = link_clk_sync[1] & ~link_clk_prev;
    // Wire as it stood before the link edge; the far side moves it just after
    assign line_now = sirq_prev;
    assign power_good = pg_sync[1];

    // =======================================================
    // Register file
    logic [15:0] slot_own;
    logic [7:0] smi_en2;
    logic [7:0] osc_cfg;
    logic bus_req;
    logic bus_write;
    logic [31:0] wmask;
    serial_irq_pkg::status_s status;

    assign bus_req = cyc_i & stb_i;
    // A write commits on the edge where ack is seen high
    assign bus_write = bus_req & we_i & ack_o & power_good;
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

    // Single-wait-state acknowledge; unmapped reads return zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
        end
        else
        begin
            ack_o <= bus_req & ~ack_o;
        end
    end

    // Read data captured as ack rises
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_o <= 32'h0000_0000;
        end
        else if (bus_req & ~ack_o)
        begin
            dat_o <= 32'h0000_0000;
            if (power_good)
            begin
                case (adr_i)
                    serial_irq_pkg::ADDR_SLOT_OWN: dat_o <= {16'h0000, slot_own};
                    serial_irq_pkg::ADDR_SMI_EN2: dat_o <= {24'h00_0000, smi_en2};
                    serial_irq_pkg::ADDR_OSC_CFG: dat_o <= {24'h00_0000, osc_cfg};
                    serial_irq_pkg::ADDR_STATUS: dat_o <= status;
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Writable registers; line zero has no period and stays unowned
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            slot_own <= serial_irq_pkg::SLOT_OWN_RESET;
            smi_en2 <= serial_irq_pkg::SMI_EN2_RESET;
            osc_cfg <= serial_irq_pkg::OSC_CFG_RESET;
        end
        else if (bus_write)
        begin
            case (adr_i)
                serial_irq_pkg::ADDR_SLOT_OWN:
                    slot_own <= ((slot_own & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]))
                        & 16'hFFFE;
                serial_irq_pkg::ADDR_SMI_EN2:
                    smi_en2 <= (smi_en2 & ~wmask[7:0]) | (dat_i[7:0] & wmask[7:0]);
                serial_irq_pkg::ADDR_OSC_CFG:
                    osc_cfg <= (osc_cfg & ~wmask[7:0]) | (dat_i[7:0] & wmask[7:0]);
                default: ;
            endcase
        end
    end

    // =======================================================
    // Side outputs
    // crystal load select
    assign crystal_load_select_o = osc_cfg[serial_irq_pkg::XTAL_LOAD_BIT];

    // IR timeout gated by power good
    assign ir_timeout_enable_o = power_good;

    // pin route gated by enable bit 7
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            system_mgmt_interrupt_n_o <= 1'b1;
        end
        else
        begin
            system_mgmt_interrupt_n_o <=
                ~(smi_active_i & smi_en2[serial_irq_pkg::SMI_PIN_BIT]);
        end
    end

    // =======================================================
    // Effective slot levels: high means nothing to report
    logic [NUM_LINES-1:0] slot_level;
    logic [NUM_LINES-1:0] slot_level_prev;
    logic [NUM_LINES-1:0] slot_snap;
    logic [NUM_LINES-1:0] pending;
    logic smi_frame_level;

    // frame route gated by enable bit 6
    assign smi_frame_level =
        ~(smi_active_i & smi_en2[serial_irq_pkg::SMI_FRAME_BIT]);

    // =======================================================
    // Link state
    serial_irq_pkg::link_state_e state;
    logic quiet_mode;
    logic [1:0] phase;
    logic [1:0] next_phase;
    logic [4:0] frame;
    logic [2:0] low_run;
    logic [2:0] stop_width;
    logic [1:0] idle_cnt;
    logic drove_low;
    logic line_active;
    logic want_start;
    logic snap_now;

    assign next_phase = (phase == serial_irq_pkg::PHASE_RECOVER) ?
        serial_irq_pkg::PHASE_TURN : phase + 2'd1;
    // Levels are latched at the turn-around before each slot
    assign snap_now = link_rise & (state == serial_irq_pkg::LINK_FRAMES)
        & (next_phase == serial_irq_pkg::PHASE_TURN);
    assign line_active = (state != serial_irq_pkg::LINK_IDLE);

    // Per line: owned level, change detection and pending start
    genvar k;
    generate
        for (k = 0; k < NUM_LINES; k++)
        begin : g_line
            logic deliverable;
            logic changed;
            logic own_level;

            // period three merges line two and management interrupt
            if (k == serial_irq_pkg::SMI_LINE)
            begin : g_smi
                assign own_level = (~slot_own[k] | irq_level_i[k]) & smi_frame_level;
            end
            else
            begin : g_irq
                // period fourteen follows the same map
                assign own_level = ~slot_own[k] | irq_level_i[k];
            end
            assign slot_level[k] = own_level;
            assign changed = own_level ^ slot_level_prev[k];
            // still deliverable if slot not latched yet
            assign deliverable = (state == serial_irq_pkg::LINK_START)
                || (state == serial_irq_pkg::LINK_DRIVE_START)
                || ((state == serial_irq_pkg::LINK_FRAMES) && (5'(k + 1) > frame)
                    && !(snap_now && (5'(k) == frame)));

            // Set wins over the clear from the slot latch
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    pending[k] <= 1'b0;
                    slot_level_prev[k] <= 1'b1;
                    slot_snap[k] <= 1'b1;
                end
                else
                begin
                    slot_level_prev[k] <= own_level;
                    // latch level before its sample phase
                    if (snap_now && (5'(k) == frame))
                    begin
                        slot_snap[k] <= own_level;
                    end
                    if (changed && !deliverable)
                    begin
                        pending[k] <= 1'b1;
                    end
                    else if (snap_now && (5'(k) == frame))
                    begin
                        pending[k] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // quiet mode lets us request a cycle
    // continuous mode keeps the agent passive
    // hold off after a quiet stop
    assign want_start = (|pending) & quiet_mode & (idle_cnt >= serial_irq_pkg::START_HOLDOFF);

    // Frame tracking state machine, advanced on each link rising edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= serial_irq_pkg::LINK_IDLE;
            quiet_mode <= 1'b0;
            phase <= serial_irq_pkg::PHASE_TURN;
            frame <= 5'd0;
            low_run <= 3'd0;
            stop_width <= 3'd0;
            idle_cnt <= 2'd0;
        end
        else if (link_rise)
        begin
            case (state)
                serial_irq_pkg::LINK_IDLE:
                begin
                    if (idle_cnt != 2'd3)
                    begin
                        idle_cnt <= idle_cnt + 2'd1;
                    end
                    // someone else started: follow the low run
                    if (!line_now)
                    begin
                        state <= serial_irq_pkg::LINK_START;
                    end
                    else if (want_start)
                    begin
                        state <= serial_irq_pkg::LINK_DRIVE_START;
                    end
                end
                serial_irq_pkg::LINK_DRIVE_START:
                begin
                    state <= serial_irq_pkg::LINK_START;
                end
                serial_irq_pkg::LINK_START:
                begin
                    // counting begins at the rising edge
                    if (line_now)
                    begin
                        state <= serial_irq_pkg::LINK_FRAMES;
                        phase <= serial_irq_pkg::PHASE_TURN;
                        frame <= serial_irq_pkg::FIRST_FRAME;
                        low_run <= 3'd0;
                    end
                end
                serial_irq_pkg::LINK_FRAMES:
                begin
                    phase <= next_phase;
                    if ((phase == serial_irq_pkg::PHASE_RECOVER) && (frame != 5'd31))
                    begin
                        frame <= frame + 5'd1;
                    end
                    // Data slots are one clock low; two in a row is a stop
                    if (!line_now)
                    begin
                        low_run <= low_run + 3'd1;
                        if (low_run != 3'd0)
                        begin
                            state <= serial_irq_pkg::LINK_STOP;
                        end
                    end
                    else
                    begin
                        low_run <= 3'd0;
                    end
                end
                serial_irq_pkg::LINK_STOP:
                begin
                    // mode taken from every stop width
                    if (line_now)
                    begin
                        stop_width <= low_run;
                        quiet_mode <= (low_run == serial_irq_pkg::STOP_QUIET_WIDTH);
                        idle_cnt <= 2'd0;
                        frame <= 5'd0;
                        state <= serial_irq_pkg::LINK_IDLE;
                    end
                    else if (low_run != 3'd7)
                    begin
                        low_run <= low_run + 3'd1;
                    end
                end
                default:
                begin
                    state <= serial_irq_pkg::LINK_IDLE;
                end
            endcase
        end
    end

    // =======================================================
    // Wire drive, changed only just after a link rising edge
    serial_irq_pkg::pin_drive_s drive;
    logic slot_low;

    // our slot only, when latched level low
    // independent of who started the cycle
    assign slot_low = (frame > serial_irq_pkg::FIRST_FRAME)
        && (frame <= serial_irq_pkg::LAST_FRAME)
        && !slot_snap[frame[3:0] - 4'd1];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            drive <= '{oe: 1'b0, level: 1'b1};
            drove_low <= 1'b0;
        end
        else if (link_rise)
        begin
            drive <= '{oe: 1'b0, level: 1'b1};
            drove_low <= 1'b0;
            case (state)
                serial_irq_pkg::LINK_IDLE:
                begin
                    if (line_now && want_start)
                    begin
                        drive <= '{oe: 1'b1, level: 1'b0};
                    end
                end
                serial_irq_pkg::LINK_FRAMES:
                begin
                    if (!line_now && (low_run != 3'd0))
                    begin
                        drive <= '{oe: 1'b0, level: 1'b1};
                    end
                    else if ((next_phase == serial_irq_pkg::PHASE_SAMPLE) && slot_low)
                    begin
                        drive <= '{oe: 1'b1, level: 1'b0};
                        drove_low <= 1'b1;
                    end
                    // recovery drives high after own low
                    else if ((next_phase == serial_irq_pkg::PHASE_RECOVER) && drove_low)
                    begin
                        drive <= '{oe: 1'b1, level: 1'b1};
                    end
                end
                // start pulse ends released, never high
                default: ;
            endcase
        end
    end

    assign sirq_o = drive.level;
    assign sirq_oe_o = drive.oe;

    // =======================================================
    // Status word
    always_comb
    begin
        status = '0;
        status.pending = pending;
        status.frame = frame;
        status.stop_width = stop_width;
        status.reserved_lo = {3'b000, line_active, quiet_mode};
    end

endmodule : serial_irq_slave_agent

// [testbench/serial_irq_sva_assertions.sv]
// Port checker for the serial interrupt slave agent
`timescale 1ns/10ps

module serial_irq_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic smi_active_i,
    input wire logic system_mgmt_interrupt_n_o,
    input wire logic ir_timeout_enable_o,
    input wire logic crystal_load_select_o,
    input wire logic sirq_o,
    input wire logic sirq_oe_o
);
    // ==========
    // Helpers: one-bit views of the pin drive and of a load write
    logic drv_lo, drv_hi, osc_wr, wr_bit;
    assign drv_lo = sirq_oe_o && !sirq_o;
    assign drv_hi = sirq_oe_o && sirq_o;
    assign osc_wr = ack_o && we_i && adr_i == serial_irq_pkg::ADDR_OSC_CFG && sel_i[0];
    assign wr_bit = dat_i[serial_irq_pkg::XTAL_LOAD_BIT];
    default clocking
        @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ==========
    // Assertions
    a_reset_state:
        assert property ($fell(rst_i) |-> !sirq_oe_o && !ack_o && system_mgmt_interrupt_n_o)
        else $error("outputs not idle after reset");
    a_bus_answer:
        assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus answer not a single pulse");
    a_gated_read:
        assert property (ack_o && !we_i && !ir_timeout_enable_o
            && !$past(ir_timeout_enable_o) |-> dat_o == 32'h0)
        else $error("read data while power good low");
    a_load_write:
        assert property (osc_wr && ir_timeout_enable_o && $past(ir_timeout_enable_o)
            |=> crystal_load_select_o == $past(wr_bit))
        else $error("load select missed a write");
    a_mgmt_pin:
        assert property (!$past(smi_active_i) |-> system_mgmt_interrupt_n_o)
        else $error("management pin low without source");
    a_high_after_low:
        assert property ($rose(drv_hi) |-> $past(drv_lo))
        else $error("wire driven high without own low");
    a_low_one_clock:
        assert property ($rose(drv_lo) |=> drv_lo[*8] ##[1:7] !drv_lo)
        else $error("low drive not one link clock");
    a_turn_release:
        assert property ($rose(drv_hi) |=> drv_hi[*8] ##[1:7] !sirq_oe_o)
        else $error("wire not released after recovery");

    // Main scenarios reached
    c_agent_low: cover property ($rose(drv_lo));
    c_recovery: cover property ($rose(drv_hi));
    c_gated_write: cover property (osc_wr && !ir_timeout_enable_o);
endmodule : serial_irq_sva

bind serial_irq_slave_agent serial_irq_sva serial_irq_sva_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .smi_active_i(smi_active_i), .system_mgmt_interrupt_n_o(system_mgmt_interrupt_n_o),
    .ir_timeout_enable_o(ir_timeout_enable_o),
    .crystal_load_select_o(crystal_load_select_o), .sirq_o(sirq_o), .sirq_oe_o(sirq_oe_o)
);

// [testbench/sirq_host_model.sv]
// Behavioural host serial interrupt controller
`timescale 1ns/10ps

module sirq_host_model (
    input wire logic link_clk_i,
    input wire logic wire_i,
    output logic oe_o,
    output logic lvl_o
);
    // ==========
    // Wire drive and host samples, period n in bit n-1
    logic [15:0] samples;

    initial
    begin
        oe_o = 1'b0;
        lvl_o = 1'b1;
    end

    task drive(input logic oe, input logic lvl, input int n);
        repeat (n)
        begin
            @(posedge link_clk_i);
            oe_o <= oe;
            lvl_o <= lvl;
        end
    endtask : drive

    task wait_start(input int lim, output bit seen);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++)
        begin
            @(posedge link_clk_i);
            if (wire_i === 1'b0)
            begin
                seen = 1'b1;
                oe_o <= 1'b1;
                lvl_o <= 1'b0;
            end
        end
    endtask : wait_start

    // One cycle: start, sixteen frames, stop
    task cycle(input int low_n, input int stop_n, input bit agent);
        drive(1'b1, 1'b0, agent ? low_n - 2 : low_n);
        drive(1'b1, 1'b1, 1);
        drive(1'b0, 1'b1, 1);
        for (int k = 1; k <= 48; k++)
        begin
            @(posedge link_clk_i);
            if (k % 3 == 2)
                samples[k / 3] = wire_i;
        end
        drive(1'b1, 1'b0, stop_n);
        drive(1'b1, 1'b1, 1);
        drive(1'b0, 1'b1, 1);
    endtask : cycle
endmodule : sirq_host_model

// [testbench/test_serial_irq_slave_agent.sv]
// Self-checking bench for the serial interrupt slave agent
`timescale 1ns/10ps

module test_serial_irq_slave_agent;
    // ==========
    // Signals and counters
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, link_clk_i, sirq_o, sirq_oe_o;
    logic smi_active_i, system_mgmt_interrupt_n_o, internal_power_good_i, sirq_wire;
    logic ir_timeout_enable_o, crystal_load_select_o, host_oe, host_lvl;
    logic [3:0] adr_i, sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [15:0] irq_level_i, own;
    bit seen;
    int fails;
    int comparisons;

    // Pull-up wire; the agent wins a clash so its level shows
    assign sirq_wire = sirq_oe_o ? sirq_o : (host_oe ? host_lvl : 1'b1);

    serial_irq_slave_agent serial_irq_slave_agent_i (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .irq_level_i(irq_level_i), .smi_active_i(smi_active_i),
        .system_mgmt_interrupt_n_o(system_mgmt_interrupt_n_o),
        .internal_power_good_i(internal_power_good_i),
        .ir_timeout_enable_o(ir_timeout_enable_o),
        .crystal_load_select_o(crystal_load_select_o), .link_clk_i(link_clk_i),
        .sirq_i(sirq_wire), .sirq_o(sirq_o), .sirq_oe_o(sirq_oe_o)
    );

    sirq_host_model sirq_host_model_i (
        .link_clk_i(link_clk_i), .wire_i(sirq_wire), .oe_o(host_oe), .lvl_o(host_lvl)
    );

    // ==========
    // Clocks; the link rising edges fall between system edges
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Link clock runs free like a bus clock
    initial
    begin
        link_clk_i = 1'b0;
        forever #62.5 link_clk_i = ~link_clk_i;
    end

    // ==========
    // Checking and bus tasks
    task stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : chk

    // Owned low lines pull their period low; period one stays high
    task chk_frames(input string what, input logic [15:0] lvl, input logic smi);
        logic [15:0] e;
        e = ~(own & ~lvl) | 16'h0001;
        e[serial_irq_pkg::SMI_LINE] &= !smi;
        chk(what, 32'(e), 32'(sirq_host_model_i.samples));
    endtask : chk_frames

    // Classic cycle held until ack; a stuck bus is left to the watchdog
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hF, d};
        do
            @(posedge clk_i);
        while (ack_o !== 1'b1);
        rd = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
        @(posedge clk_i);
        chk("bus ack drop", 32'h0, 32'(ack_o));
    endtask : wb

    // ==========
    // Scenarios
    task t_regs();
        wb(1'b0, serial_irq_pkg::ADDR_SLOT_OWN, 32'h0);
        chk("owner reset", 32'(serial_irq_pkg::SLOT_OWN_RESET), rd);
        wb(1'b0, serial_irq_pkg::ADDR_SMI_EN2, 32'h0);
        chk("enable reset", 32'(serial_irq_pkg::SMI_EN2_RESET), rd);
        wb(1'b0, 4'h2, 32'h0);
        chk("unmapped read", 32'h0, rd);
        wb(1'b1, serial_irq_pkg::ADDR_SLOT_OWN, 32'hFFFF_FFFF);
        wb(1'b0, serial_irq_pkg::ADDR_SLOT_OWN, 32'h0);
        chk("owner bit zero", 32'h0000_FFFE, rd);
        chk("load default", 32'h0, 32'(crystal_load_select_o));
        wb(1'b1, serial_irq_pkg::ADDR_OSC_CFG, 32'h0000_0040);
        wb(1'b0, serial_irq_pkg::ADDR_OSC_CFG, 32'h0);
        chk("load select", 32'h1, 32'(crystal_load_select_o));
        $display("register test done");
    endtask : t_regs

    task t_host();
        own = 16'h2022;
        wb(1'b1, serial_irq_pkg::ADDR_SLOT_OWN, 32'(own));
        irq_level_i <= 16'hDFD7;
        sirq_host_model_i.cycle(4, 2, 1'b0);
        chk_frames("host frames", 16'hDFD7, 1'b0);
        repeat (4) @(posedge clk_i);
        wb(1'b0, serial_irq_pkg::ADDR_STATUS, 32'h0);
        chk("quiet status", 32'h0000_000A, rd & 32'h0000_001F);
        $display("host cycle test done");
    endtask : t_host

    task t_quiet();
        irq_level_i <= 16'hDFF7;
        sirq_host_model_i.wait_start(40, seen);
        chk("agent start", 32'h1, 32'(seen));
        sirq_host_model_i.cycle(6, 3, 1'b1);
        chk_frames("quiet frames", 16'hDFF7, 1'b0);
        $display("quiet start test done");
    endtask : t_quiet

    task t_cont();
        wb(1'b1, serial_irq_pkg::ADDR_SMI_EN2, 32'h0000_0040);
        irq_level_i <= 16'hDFD7;
        smi_active_i <= 1'b1;
        sirq_host_model_i.wait_start(30, seen);
        chk("no agent start", 32'h0, 32'(seen));
        sirq_host_model_i.cycle(8, 3, 1'b0);
        chk_frames("shared frame", 16'hDFD7, 1'b1);
        chk("pin off", 32'h1, 32'(system_mgmt_interrupt_n_o));
        wb(1'b1, serial_irq_pkg::ADDR_SMI_EN2, 32'h0000_0080);
        wb(1'b0, serial_irq_pkg::ADDR_SMI_EN2, 32'h0);
        chk("pin on", 32'h0, 32'(system_mgmt_interrupt_n_o));
        smi_active_i <= 1'b0;
        $display("continuous test done");
    endtask : t_cont

    task t_power();
        internal_power_good_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("timeout off", 32'h0, 32'(ir_timeout_enable_o));
        wb(1'b1, serial_irq_pkg::ADDR_OSC_CFG, 32'h0);
        wb(1'b0, serial_irq_pkg::ADDR_OSC_CFG, 32'h0);
        chk("gated read", 32'h0, rd);
        chk("gated write", 32'h1, 32'(crystal_load_select_o));
        internal_power_good_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        wb(1'b0, serial_irq_pkg::ADDR_OSC_CFG, 32'h0);
        chk("load kept", 32'h0000_0040, rd);
        chk("timeout on", 32'h1, 32'(ir_timeout_enable_o));
        $display("power good test done");
    endtask : t_power

    // Main sequence
    initial
    begin
        {fails, comparisons} = 0;
        {rst_i, cyc_i, stb_i, we_i, smi_active_i} = 5'h10;
        {adr_i, sel_i, dat_i, own} = {8'h0F, 48'h0};
        irq_level_i = 16'hFFFF;
        internal_power_good_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_host();
        t_quiet();
        t_cont();
        t_power();
        stop_test();
    end

    // Watchdog; the run needs about 28 us
    initial
    begin
        #100000;
        fails++;
        stop_test();
    end
endmodule : test_serial_irq_slave_agent
